// *** fbc_coupler_map.vh ***
`ifndef FBC_COUPLER_MAP_VH
`define FBC_COUPLER_MAP_VH
// ==================================================
// Register offsets
`define FBC_REG_CTRL 8'h00
`define FBC_REG_STATUS 8'h04
`define FBC_REG_MASK 8'h08
`define FBC_REG_SIZES 8'h0c
`define FBC_REG_PDO_ADDR 8'h10
`define FBC_REG_IN_STAT 8'h14
// ==================================================
// Field positions and reset values
`define FBC_CTRL_ETH_EN_LSB 0
`define FBC_CTRL_RST 32'h0000_0000
`define FBC_MASK_RST 5'h00
`define FBC_PDO_ADDR_RST 32'h0000_0000
`define FBC_EV_MAP 0
`define FBC_EV_MISMATCH 1
`define FBC_EV_EOE_DROP 2
`define FBC_EV_FWD 3
`define FBC_EV_ABORT 4
`define FBC_STAT_MISMATCH_BIT 7
// ==================================================
// Object indices
`define FBC_IDX_OUT_MAP_HI 10'h058
`define FBC_IDX_IN_MAP_HI 10'h068
`define FBC_IDX_CLIENT_STAT 16'h2003
`define FBC_IDX_FW_INFO 16'h200d
`define FBC_IDX_CLIENT_XCHG 16'h200e
`define FBC_FW_INFO_LAST_SUB 8'h15
// ==================================================
// Shared mailbox memory layout
`define FBC_MBX_COE_E2C_ADDR 16'h0100
`define FBC_MBX_COE_E2C_SIZE 16'h0060
`define FBC_MBX_COE_C2E_ADDR 16'h0200
`define FBC_MBX_COE_C2E_SIZE 16'h0060
`define FBC_MBX_VOE_E2C_ADDR 16'h0300
`define FBC_MBX_VOE_E2C_SIZE 16'h0080
`define FBC_MBX_VOE_C2E_ADDR 16'h0400
`define FBC_MBX_VOE_C2E_SIZE 16'h0080
`define FBC_MBX_CTL_INFO 16'h0010
`define FBC_MBX_CTL_COE_RD 16'h0011
`define FBC_MBX_CTL_COE_WR 16'h0012
`define FBC_MBX_CTL_VOE_RD 16'h0013
`define FBC_MBX_CTL_VOE_WR 16'h0014
`endif

// *** fbc_sync3.v ***
// ==================================================
// Three-stage pin synchroniser, change taken when stages two and three agree
module fbc_sync3 #(
  parameter WIDTH = 2
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= {WIDTH{1'b0}};
      s2_reg <= {WIDTH{1'b0}};
      s3_reg <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Per-bit agreement filters single-cycle glitches
      level <= (s2_reg & s3_reg) | (level & (s2_reg | s3_reg));
    end
  end
endmodule

// *** fbc_sticky.v ***
// ==================================================
// Sticky event bits, write one to clear, set wins over clear
module fbc_sticky #(
  parameter WIDTH = 5
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clr,
  output reg [WIDTH-1:0] flags
);
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags <= {WIDTH{1'b0}};
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end
endmodule

// *** fbc_coupler.v ***
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`include "fbc_coupler_map.vh"
module fbc_coupler (
  input wire clock,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output wire irq,
  input wire sdo_req,
  input wire sdo_wr,
  input wire [15:0] sdo_index,
  input wire [7:0] sdo_sub,
  input wire [31:0] sdo_wdata,
  output reg sdo_done,
  output reg sdo_abort,
  output reg [31:0] sdo_rdata,
  output reg sdo_to_local,
  output reg sdo_to_client,
  input wire [15:0] client_out_size,
  input wire [15:0] client_in_size,
  input wire fw_setup_done,
  input wire fw_pdo_avail,
  input wire fw_coe_avail,
  input wire fw_voe_avail,
  input wire [7:0] esm_state,
  input wire mbx_update,
  input wire pdo_in_strobe,
  input wire uplink_pin,
  input wire pll_lock_pin,
  output reg [15:0] out_pdo_size,
  output reg [15:0] in_pdo_size,
  output reg [15:0] in_frame_size,
  output reg [7:0] in_status_byte,
  input wire [2:0] eth_rx_valid,
  input wire [23:0] eth_rx_data,
  input wire [2:0] eth_rx_last,
  output reg [2:0] eth_rx_ready,
  output wire [2:0] eth_tx_valid,
  output reg [7:0] eth_tx_data,
  output reg eth_tx_last,
  input wire [2:0] eth_tx_ready,
  output wire mgr_tx_valid,
  input wire mgr_tx_ready,
  input wire ecat_eoe_valid,
  input wire ecat_eoe_last,
  output wire ecat_eoe_ready
);
  // ==================================================
  // Reset release
  reg rst_s1_reg;
  reg rst_n_reg;
  wire rst_n;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_n_reg;

  // ==================================================
  // Pin inputs
  wire [1:0] pin_level;
  wire uplink_ok;
  wire pll_locked;
  fbc_sync3 #(.WIDTH(2)) u_sync (
    .clock(clock),
    .reset_n(rst_n),
    .pin({pll_lock_pin, uplink_pin}),
    .level(pin_level)
  );
  assign uplink_ok = pin_level[0];
  assign pll_locked = pin_level[1];

  // ==================================================
  // Software registers
  reg [31:0] ctrl_reg;
  reg [4:0] mask_reg;
  reg [31:0] pdo_addr_reg;
  wire [4:0] ev_flags;
  reg [4:0] ev_set;
  wire [4:0] ev_clr;
  wire [2:0] eth_en;
  assign eth_en = ctrl_reg[`FBC_CTRL_ETH_EN_LSB +: 3];
  assign ev_clr = (reg_wr && reg_addr == `FBC_REG_STATUS) ? reg_wdata[4:0] : 5'h00;
  assign irq = |(ev_flags & mask_reg);

  fbc_sticky #(.WIDTH(5)) u_events (
    .clock(clock),
    .reset_n(rst_n),
    .set(ev_set),
    .clr(ev_clr),
    .flags(ev_flags)
  );

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `FBC_CTRL_RST;
      mask_reg <= `FBC_MASK_RST;
      pdo_addr_reg <= `FBC_PDO_ADDR_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `FBC_REG_CTRL: begin
          ctrl_reg <= {29'h0, reg_wdata[2:0]};
        end
        `FBC_REG_MASK: begin
          mask_reg <= reg_wdata[4:0];
        end
        `FBC_REG_PDO_ADDR: begin
          pdo_addr_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FBC_REG_CTRL: reg_rdata <= ctrl_reg;
        `FBC_REG_STATUS: reg_rdata <= {27'h0, ev_flags};
        `FBC_REG_MASK: reg_rdata <= {27'h0, mask_reg};
        `FBC_REG_SIZES: reg_rdata <= {in_pdo_size, out_pdo_size};
        `FBC_REG_PDO_ADDR: reg_rdata <= pdo_addr_reg;
        `FBC_REG_IN_STAT: reg_rdata <= {24'h0, in_status_byte};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==================================================
  // Process data mapping
  reg out_map_on_reg;
  reg [5:0] out_map_n_reg;
  reg in_map_on_reg;
  reg [5:0] in_map_n_reg;
  wire is_out_map;
  wire is_in_map;
  wire [15:0] out_size_next;
  wire [15:0] in_size_next;
  wire mismatch;
  reg mismatch_reg;
  assign is_out_map = sdo_index[15:6] == `FBC_IDX_OUT_MAP_HI;
  assign is_in_map = sdo_index[15:6] == `FBC_IDX_IN_MAP_HI;
  assign out_size_next = out_map_on_reg ? {6'h00, {1'b0, out_map_n_reg} + 7'h01, 3'h0} : 16'h0000;
  assign in_size_next = in_map_on_reg ? {6'h00, {1'b0, in_map_n_reg} + 7'h01, 3'h0} : 16'h0000;
  assign mismatch = (out_size_next != client_out_size) || (in_size_next != client_in_size);

  // Activation replaces the previous one, so sizes never add up
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_map_on_reg <= 1'b0;
      out_map_n_reg <= 6'h00;
      in_map_on_reg <= 1'b0;
      in_map_n_reg <= 6'h00;
    end else if (sdo_req && sdo_wr) begin
      if (is_out_map) begin
        if (sdo_wdata != 32'h0000_0000) begin
          out_map_on_reg <= 1'b1;
          out_map_n_reg <= sdo_index[5:0];
        end else if (sdo_index[5:0] == out_map_n_reg) begin
          out_map_on_reg <= 1'b0;
        end
      end
      if (is_in_map) begin
        if (sdo_wdata != 32'h0000_0000) begin
          in_map_on_reg <= 1'b1;
          in_map_n_reg <= sdo_index[5:0];
        end else if (sdo_index[5:0] == in_map_n_reg) begin
          in_map_on_reg <= 1'b0;
        end
      end
    end
  end

  // ==================================================
  // Input status byte
  reg [3:0] hb_reg;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hb_reg <= 4'h0;
      mismatch_reg <= 1'b0;
      out_pdo_size <= 16'h0000;
      in_pdo_size <= 16'h0000;
      in_frame_size <= 16'h0000;
      in_status_byte <= 8'h00;
    end else begin
      if (pdo_in_strobe && fw_setup_done && !mismatch) begin
        hb_reg <= hb_reg + 4'h1;
      end
      mismatch_reg <= mismatch;
      out_pdo_size <= out_size_next;
      in_pdo_size <= in_size_next;
      in_frame_size <= in_map_on_reg ? in_size_next + 16'h0001 : 16'h0000;
      in_status_byte <= {mismatch, 3'h0, hb_reg};
    end
  end

  // ==================================================
  // Mailbox update counter and time
  reg [31:0] time_reg;
  reg [31:0] upd_cnt_reg;
  reg [31:0] upd_time_reg;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      time_reg <= 32'h0000_0000;
      upd_cnt_reg <= 32'h0000_0000;
      upd_time_reg <= 32'h0000_0000;
    end else begin
      time_reg <= time_reg + 32'h0000_0001;
      if (mbx_update) begin
        upd_cnt_reg <= upd_cnt_reg + 32'h0000_0001;
        upd_time_reg <= time_reg;
      end
    end
  end

  // ==================================================
  // Service object answers
  reg [31:0] info_val;
  reg info_ok;
  always @* begin
    info_val = 32'h0000_0000;
    info_ok = 1'b1;
    case (sdo_sub)
      8'h00: info_val = {24'h0, `FBC_FW_INFO_LAST_SUB};
      8'h01: info_val = {28'h0, fw_voe_avail, fw_coe_avail, fw_pdo_avail, fw_setup_done};
      8'h02: info_val = {24'h0, esm_state};
      8'h03: info_val = {16'h0, pdo_addr_reg[15:0]};
      8'h04: info_val = {16'h0, out_size_next};
      8'h05: info_val = {16'h0, pdo_addr_reg[31:16]};
      8'h06: info_val = {16'h0, in_size_next};
      8'h07: info_val = {16'h0, `FBC_MBX_COE_E2C_ADDR};
      8'h08: info_val = {16'h0, `FBC_MBX_COE_E2C_SIZE};
      8'h09: info_val = {16'h0, `FBC_MBX_COE_C2E_ADDR};
      8'h0a: info_val = {16'h0, `FBC_MBX_COE_C2E_SIZE};
      8'h0b: info_val = {16'h0, `FBC_MBX_VOE_E2C_ADDR};
      8'h0c: info_val = {16'h0, `FBC_MBX_VOE_E2C_SIZE};
      8'h0d: info_val = {16'h0, `FBC_MBX_VOE_C2E_ADDR};
      8'h0e: info_val = {16'h0, `FBC_MBX_VOE_C2E_SIZE};
      8'h0f: info_val = {16'h0, `FBC_MBX_CTL_INFO};
      8'h10: info_val = {16'h0, `FBC_MBX_CTL_COE_RD};
      8'h11: info_val = {16'h0, `FBC_MBX_CTL_COE_WR};
      8'h12: info_val = {16'h0, `FBC_MBX_CTL_VOE_RD};
      8'h13: info_val = {16'h0, `FBC_MBX_CTL_VOE_WR};
      8'h14: info_val = upd_cnt_reg;
      8'h15: info_val = upd_time_reg;
      default: info_ok = 1'b0;
    endcase
  end

  reg abort_next;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdo_done <= 1'b0;
      sdo_abort <= 1'b0;
      sdo_rdata <= 32'h0000_0000;
      sdo_to_local <= 1'b0;
      sdo_to_client <= 1'b0;
    end else begin
      sdo_done <= sdo_req;
      sdo_abort <= sdo_req && abort_next;
      sdo_to_local <= 1'b0;
      sdo_to_client <= 1'b0;
      sdo_rdata <= 32'h0000_0000;
      if (sdo_req) begin
        if (sdo_index == `FBC_IDX_CLIENT_STAT && !sdo_wr) begin
          sdo_rdata <= {29'h0, !pll_locked, pll_locked, uplink_ok};
        end else if (sdo_index == `FBC_IDX_FW_INFO && !sdo_wr) begin
          sdo_rdata <= info_val;
        end else if (sdo_index == `FBC_IDX_CLIENT_XCHG) begin
          sdo_to_client <= (sdo_sub == 8'h01) || (sdo_sub == 8'h02);
        end else if ((is_out_map || is_in_map) && !sdo_wr) begin
          sdo_rdata <= {31'h0, is_out_map ? (out_map_on_reg && out_map_n_reg == sdo_index[5:0])
                                          : (in_map_on_reg && in_map_n_reg == sdo_index[5:0])};
        end else if (!is_out_map && !is_in_map && sdo_index != `FBC_IDX_CLIENT_STAT &&
                     sdo_index != `FBC_IDX_FW_INFO) begin
          sdo_to_local <= 1'b1;
        end
      end
    end
  end

  always @* begin
    abort_next = 1'b0;
    if ((sdo_index == `FBC_IDX_CLIENT_STAT || sdo_index == `FBC_IDX_FW_INFO) && sdo_wr) begin
      abort_next = 1'b1;
    end else if (sdo_index == `FBC_IDX_FW_INFO && !info_ok) begin
      abort_next = 1'b1;
    end else if (sdo_index == `FBC_IDX_CLIENT_XCHG && sdo_sub != 8'h01 && sdo_sub != 8'h02) begin
      abort_next = 1'b1;
    end
  end

  // ==================================================
  // Ethernet tunneling hub
  reg stg_valid_reg;
  reg [2:0] stg_dest_reg;
  reg in_frame_reg;
  reg [1:0] owner_reg;
  reg [1:0] pick;
  wire [1:0] sel;
  wire drain;
  wire take;
  wire room;
  integer i;
  assign drain = stg_valid_reg && mgr_tx_ready && (&(eth_tx_ready | ~stg_dest_reg));
  assign room = !stg_valid_reg || drain;
  assign sel = in_frame_reg ? owner_reg : pick;
  assign take = eth_rx_valid[sel] && eth_en[sel] && room;
  assign eth_tx_valid = {3{stg_valid_reg}} & stg_dest_reg;
  assign mgr_tx_valid = stg_valid_reg;
  // Dropped on arrival: tunneled frames never reach the client bus
  assign ecat_eoe_ready = 1'b1;

  always @* begin
    pick = 2'd0;
    for (i = 2; i >= 0; i = i - 1) begin
      if (eth_rx_valid[i] && eth_en[i]) begin
        pick = i[1:0];
      end
    end
    // Disabled ports are drained so a non-Ethernet port never blocks the hub
    for (i = 0; i < 3; i = i + 1) begin
      eth_rx_ready[i] = !eth_en[i] || (sel == i[1:0] && room);
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stg_valid_reg <= 1'b0;
      stg_dest_reg <= 3'h0;
      eth_tx_data <= 8'h00;
      eth_tx_last <= 1'b0;
      in_frame_reg <= 1'b0;
      owner_reg <= 2'd0;
    end else begin
      if (take) begin
        stg_valid_reg <= 1'b1;
        stg_dest_reg <= eth_en & ~(3'h1 << sel);
        eth_tx_data <= eth_rx_data[sel*8 +: 8];
        eth_tx_last <= eth_rx_last[sel];
        in_frame_reg <= !eth_rx_last[sel];
        owner_reg <= sel;
      end else if (drain) begin
        stg_valid_reg <= 1'b0;
      end
    end
  end

  // ==================================================
  // Events
  always @* begin
    ev_set = 5'h00;
    ev_set[`FBC_EV_MAP] = sdo_req && sdo_wr && (is_out_map || is_in_map);
    ev_set[`FBC_EV_MISMATCH] = mismatch && !mismatch_reg;
    ev_set[`FBC_EV_EOE_DROP] = ecat_eoe_valid && ecat_eoe_last;
    ev_set[`FBC_EV_FWD] = drain && eth_tx_last;
    ev_set[`FBC_EV_ABORT] = sdo_req && abort_next;
  end
endmodule

// *** fbc_coupler_monitor.sv ***
// ==================================================
// Port checker for the coupler
module fbc_coupler_chk (
  input logic clock,
  input logic reset_n,
  input logic sdo_req,
  input logic sdo_wr,
  input logic [15:0] sdo_index,
  input logic [7:0] sdo_sub,
  input logic sdo_done,
  input logic sdo_abort,
  input logic sdo_to_local,
  input logic sdo_to_client,
  input logic [15:0] out_pdo_size,
  input logic [15:0] in_pdo_size,
  input logic [15:0] in_frame_size,
  input logic [7:0] in_status_byte,
  input logic mgr_tx_valid,
  input logic mgr_tx_ready,
  input logic ecat_eoe_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic ro;
  assign ro = sdo_index == 16'h2003 || sdo_index == 16'h200d;
  chk_done_lat: assert property (sdo_done == $past(sdo_req))
    else $error("service answer not one cycle after request");
  chk_ro_abort: assert property (sdo_req && sdo_wr && ro |=> sdo_abort && !sdo_to_client)
    else $error("write to status object not aborted");
  chk_client_xchg: assert property (sdo_req && sdo_index == 16'h200e &&
    (sdo_sub == 8'h01 || sdo_sub == 8'h02) |=> sdo_to_client && !sdo_abort && !sdo_to_local)
    else $error("exchange object not routed to client");
  chk_local_obj: assert property (sdo_req && sdo_index[15:12] == 4'h6 |=>
    sdo_to_local && !sdo_to_client) else $error("other object not answered locally");
  chk_out_step: assert property (out_pdo_size[2:0] == 3'h0 && out_pdo_size <= 16'h0200)
    else $error("output size off the eight byte grid");
  chk_frame_size: assert property (in_pdo_size != 16'h0 && $stable(in_pdo_size) |->
    in_frame_size == in_pdo_size + 16'h0001) else $error("input frame lacks status byte");
  chk_rsvd_zero: assert property (in_status_byte[6:4] == 3'h0)
    else $error("reserved status bits set");
  chk_hb_count: assert property (in_status_byte[3:0] != $past(in_status_byte[3:0]) |->
    in_status_byte[3:0] == $past(in_status_byte[3:0]) + 4'h1)
    else $error("heartbeat moved other than up by one");
  chk_hold_mgr: assert property (mgr_tx_valid && !mgr_tx_ready |=> mgr_tx_valid)
    else $error("manager byte dropped before taken");
  chk_eoe_sink: assert property (ecat_eoe_ready)
    else $error("tunnel input stalled");
endmodule
bind fbc_coupler fbc_coupler_chk i_chk (.clock, .reset_n, .sdo_req, .sdo_wr, .sdo_index,
  .sdo_sub, .sdo_done, .sdo_abort, .sdo_to_local, .sdo_to_client, .out_pdo_size,
  .in_pdo_size, .in_frame_size, .in_status_byte, .mgr_tx_valid, .mgr_tx_ready,
  .ecat_eoe_ready);

// *** fbc_hub_partner.sv ***
// ==================================================
// Client ports and bus manager taking hub bytes
module fbc_hub_partner (
  input logic clock,
  input logic stall,
  input logic [2:0] eth_tx_valid,
  input logic [7:0] eth_tx_data,
  input logic eth_tx_last,
  input logic mgr_tx_valid,
  output logic [2:0] eth_tx_ready,
  output logic mgr_tx_ready,
  output logic [2:0] seen_mask,
  output int bytes,
  output int frames,
  output logic [15:0] sum
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr = 8'h5a;
  logic take;
  initial {seen_mask, bytes, frames, sum} = '0;
  // A byte counts only when every target and the manager agree in one cycle
  assign take = mgr_tx_valid && mgr_tx_ready && (eth_tx_valid & ~eth_tx_ready) == 3'h0;
  always @(posedge clock) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    eth_tx_ready <= stall ? lfsr[2:0] : 3'h7;
    mgr_tx_ready <= stall ? lfsr[4] : 1'b1;
    if (take) begin
      seen_mask <= seen_mask | eth_tx_valid;
      bytes <= bytes + 1;
      sum <= sum + 16'(eth_tx_data);
      frames <= frames + int'(eth_tx_last);
    end
  end
endmodule

// *** fbc_coupler_tb_top.sv ***
`include "fbc_coupler_map.vh"
module fbc_coupler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, reg_wr, reg_rd, sdo_req, sdo_wr, irq, stall, sdo_done, sdo_abort;
  logic [7:0] reg_addr, sdo_sub, esm_state, in_status_byte, eth_tx_data, b;
  logic [31:0] reg_wdata, reg_rdata, sdo_wdata, sdo_rdata, d, sd, a;
  logic [15:0] sdo_index, client_out_size, client_in_size, out_pdo_size, in_pdo_size;
  logic [15:0] in_frame_size, sum, esum;
  logic sdo_to_local, sdo_to_client, fw_setup_done, fw_pdo_avail, fw_coe_avail, fw_voe_avail;
  logic mbx_update, pdo_in_strobe, uplink_pin, pll_lock_pin, eth_tx_last, mgr_tx_valid;
  logic mgr_tx_ready, ecat_eoe_valid, ecat_eoe_last, ecat_eoe_ready, r;
  logic [2:0] eth_rx_valid, eth_rx_last, eth_rx_ready, eth_tx_valid, eth_tx_ready, seen_mask;
  logic [23:0] eth_rx_data;
  logic [3:0] fl, h;
  int bad_count, check_count, bytes, frames, n, m, k, t;
  logic [15:0] mtab [13] = '{`FBC_MBX_COE_E2C_ADDR, `FBC_MBX_COE_E2C_SIZE,
    `FBC_MBX_COE_C2E_ADDR, `FBC_MBX_COE_C2E_SIZE, `FBC_MBX_VOE_E2C_ADDR, `FBC_MBX_VOE_E2C_SIZE,
    `FBC_MBX_VOE_C2E_ADDR, `FBC_MBX_VOE_C2E_SIZE, `FBC_MBX_CTL_INFO, `FBC_MBX_CTL_COE_RD,
    `FBC_MBX_CTL_COE_WR, `FBC_MBX_CTL_VOE_RD, `FBC_MBX_CTL_VOE_WR};
  fbc_coupler i_dut (.*);
  fbc_hub_partner i_hub (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==================================================
  // Expectations and bus tasks
  function automatic logic [31:0] size8(int x);
    return 32'((x + 1) * 8);
  endfunction
  function automatic logic [31:0] lnk(logic [1:0] p);
    return {29'h0, ~p[1], p[1], p[0]};
  endfunction
  task automatic finish_test;
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bound(int c, int lim);
    if (c >= lim) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic settle;
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] dt);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad);
    @(posedge clock);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic sdo(logic w, logic [15:0] i, logic [7:0] s, logic [31:0] dt);
    @(posedge clock);
    sdo_req <= 1'b1;
    sdo_wr <= w;
    sdo_index <= i;
    sdo_sub <= s;
    sdo_wdata <= dt;
    @(posedge clock);
    sdo_req <= 1'b0;
    @(negedge clock);
    fl = {sdo_done, sdo_abort, sdo_to_local, sdo_to_client};
    sd = sdo_rdata;
  endtask
  task automatic pulse(bit w, int c);
    repeat (c) begin
      @(posedge clock);
      {mbx_update, pdo_in_strobe} <= w ? 2'b10 : 2'b01;
      @(posedge clock);
      {mbx_update, pdo_in_strobe} <= 2'b00;
    end
  endtask
  // ==================================================
  // Main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, sdo_req, sdo_wr, stall, mbx_update, pdo_in_strobe} = '0;
    {fw_setup_done, fw_pdo_avail, fw_coe_avail, fw_voe_avail, uplink_pin, pll_lock_pin} = '0;
    {reg_addr, reg_wdata, sdo_index, sdo_sub, sdo_wdata, esm_state, esum} = '0;
    {client_out_size, client_in_size, eth_rx_valid, eth_rx_data, eth_rx_last} = '0;
    {ecat_eoe_valid, ecat_eoe_last, bad_count, check_count} = '0;
    void'($urandom(32'h41d27512));
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`FBC_REG_CTRL);
    cmp("ctrl", `FBC_CTRL_RST, d);
    rd(`FBC_REG_MASK);
    cmp("mask", 32'(`FBC_MASK_RST), d);
    rd(`FBC_REG_PDO_ADDR);
    cmp("pdo_addr", `FBC_PDO_ADDR_RST, d);
    rd(8'h3c);
    cmp("unmapped", 32'h0, d);
    for (int i = 0; i < 8; i++) begin
      n = i == 0 ? 0 : i == 1 ? 63 : $urandom_range(62, 1);
      m = i == 1 ? 0 : i == 0 ? 63 : $urandom_range(62, 1);
      sdo(1'b1, 16'h1600 + 16'(n), 8'h00, 32'h1);
      cmp("map_ack", 2'b10, fl[3:2]);
      sdo(1'b1, 16'h1a00 + 16'(m), 8'h00, 32'h1);
      cmp("out_size", size8(n), out_pdo_size);
      settle();
      cmp("in_size", size8(m), in_pdo_size);
      cmp("frame_size", size8(m) + 1, in_frame_size);
    end
    sdo(1'b0, 16'h1600 + 16'(n), 8'h00, 32'h0);
    cmp("map_read", 32'h1, sd);
    rd(`FBC_REG_SIZES);
    cmp("sizes", (size8(m) << 16) | size8(n), d);
    @(posedge clock);
    client_out_size <= size8(n);
    client_in_size <= size8(m);
    fw_setup_done <= 1'b1;
    wr(`FBC_REG_STATUS, 32'h1f);
    wr(`FBC_REG_MASK, 32'h2);
    settle();
    cmp("mismatch_off", 1'b0, in_status_byte[7]);
    cmp("irq_off", 1'b0, irq);
    h = in_status_byte[3:0];
    k = $urandom_range(20, 3);
    pulse(1'b0, k);
    settle();
    cmp("heartbeat", h + 4'(k), in_status_byte[3:0]);
    @(posedge clock);
    client_out_size <= size8(n) + 16'h8;
    settle();
    settle();
    cmp("mismatch_on", 1'b1, in_status_byte[7]);
    cmp("irq_on", 1'b1, irq);
    h = in_status_byte[3:0];
    pulse(1'b0, 3);
    settle();
    cmp("hb_frozen", h, in_status_byte[3:0]);
    rd(`FBC_REG_IN_STAT);
    cmp("in_stat", {24'h0, 4'h8, h}, d);
    wr(`FBC_REG_MASK, 32'h0);
    settle();
    cmp("irq_masked", 1'b0, irq);
    wr(`FBC_REG_STATUS, 32'h2);
    wr(`FBC_REG_MASK, 32'h2);
    settle();
    cmp("irq_cleared", 1'b0, irq);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {pll_lock_pin, uplink_pin} <= 2'(i);
      repeat (8) @(posedge clock);
      sdo(1'b0, 16'h2003, 8'h00, 32'h0);
      cmp("link", lnk(2'(i)), sd);
    end
    @(posedge clock);
    {fw_voe_avail, fw_coe_avail, fw_pdo_avail} <= 3'($urandom);
    esm_state <= 8'($urandom);
    a = $urandom;
    wr(`FBC_REG_PDO_ADDR, a);
    sdo(1'b0, 16'h200d, 8'h01, 32'h0);
    cmp("fw_state", {28'h0, fw_voe_avail, fw_coe_avail, fw_pdo_avail, 1'b1}, sd);
    sdo(1'b0, 16'h200d, 8'h02, 32'h0);
    cmp("esm", {24'h0, esm_state}, sd);
    sdo(1'b0, 16'h200d, 8'h03, 32'h0);
    cmp("out_addr", {16'h0, a[15:0]}, sd);
    sdo(1'b0, 16'h200d, 8'h04, 32'h0);
    cmp("out_len", size8(n), sd);
    sdo(1'b0, 16'h200d, 8'h05, 32'h0);
    cmp("in_addr", {16'h0, a[31:16]}, sd);
    sdo(1'b0, 16'h200d, 8'h06, 32'h0);
    cmp("in_len", size8(m), sd);
    for (int s = 7; s < 20; s++) begin
      sdo(1'b0, 16'h200d, 8'(s), 32'h0);
      cmp("mailbox", {16'h0, mtab[s-7]}, sd);
    end
    sdo(1'b0, 16'h200d, 8'h14, 32'h0);
    a = sd;
    k = $urandom_range(9, 1);
    pulse(1'b1, k);
    sdo(1'b0, 16'h200d, 8'h14, 32'h0);
    cmp("upd_count", a + 32'(k), sd);
    sdo(1'b0, 16'h200d, 8'h15, 32'h0);
    a = sd;
    // Two update reads plus one pulse put six cycles between the updates
    pulse(1'b1, 1);
    sdo(1'b0, 16'h200d, 8'h15, 32'h0);
    cmp("upd_time", a + 32'h6, sd);
    sdo(1'b0, 16'h200d, 8'h00, 32'h0);
    cmp("last_sub", 32'h15, sd);
    sdo(1'b0, 16'h200d, 8'h16, 32'h0);
    cmp("sub_range", 2'b11, fl[3:2]);
    sdo(1'b1, 16'h200d, 8'h01, 32'hff);
    cmp("fw_ro", 2'b11, fl[3:2]);
    sdo(1'b1, 16'h2003, 8'h00, 32'hff);
    cmp("link_ro", 2'b11, fl[3:2]);
    rd(`FBC_REG_STATUS);
    cmp("abort_ev", 1'b1, d[`FBC_EV_ABORT]);
    sdo(1'b1, 16'h200e, 8'h01, $urandom);
    cmp("xchg_out", 4'b1001, fl);
    sdo(1'b0, 16'h200e, 8'h02, 32'h0);
    cmp("xchg_back", 4'b1001, fl);
    sdo(1'b0, 16'h200e, 8'h03, 32'h0);
    cmp("xchg_bad", 2'b11, fl[3:2]);
    sdo(1'b0, {4'h6, 12'($urandom)}, 8'h00, 32'h0);
    cmp("local", 4'b1010, fl);
    wr(`FBC_REG_CTRL, 32'h3);
    @(posedge clock);
    stall <= 1'b1;
    k = $urandom_range(12, 2);
    for (int i = 0; i < k; i++) begin
      b = 8'($urandom);
      esum = esum + 16'(b);
      eth_rx_valid <= 3'h1;
      eth_rx_data <= {16'h0, b};
      eth_rx_last <= {2'h0, i == k - 1};
      t = 0;
      do begin
        @(negedge clock);
        r = eth_rx_ready[0];
        @(posedge clock);
        t++;
      end while (!r && t < 500);
      bound(t, 500);
    end
    eth_rx_valid <= 3'h0;
    for (t = 0; t < 2000 && frames < 1; t++) @(posedge clock);
    bound(t, 2000);
    cmp("fwd_targets", 3'b010, seen_mask);
    cmp("fwd_bytes", k, bytes);
    cmp("fwd_sum", esum, sum);
    rd(`FBC_REG_STATUS);
    cmp("fwd_ev", 1'b1, d[`FBC_EV_FWD]);
    @(posedge clock);
    {ecat_eoe_valid, ecat_eoe_last} <= 2'b11;
    @(posedge clock);
    {ecat_eoe_valid, ecat_eoe_last} <= 2'b00;
    repeat (6) @(posedge clock);
    cmp("eoe_blocked", 1, frames);
    rd(`FBC_REG_STATUS);
    cmp("eoe_drop_ev", 1'b1, d[`FBC_EV_EOE_DROP]);
    finish_test();
  end
endmodule
